// ### inc/ssfa_map.svh
`ifndef SSFA_MAP_SVH
`define SSFA_MAP_SVH

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define SSFA_SR_C 0
`define SSFA_SR_Z 1
`define SSFA_SR_N 2
`define SSFA_SR_GIE 3
`define SSFA_SR_CPU_OFF_BIT 4
`define SSFA_SR_OSCILLATOR_OFF_BIT 5
`define SSFA_SR_V 8
`define SSFA_SR_PCHI_LSB 12
`define SSFA_SR_PCHI_MSB 15

// ----------------------------------------
// Masks and constants
// ----------------------------------------
`define SSFA_SR_KEEP 16'h013F
`define SSFA_SR_MODE 16'h0038
`define SSFA_SR_RESET 16'h0000
`define SSFA_SET_C_MASK 16'h0001
`define SSFA_SET_Z_MASK 16'h0002
`define SSFA_SET_N_MASK 16'h0004
`define SSFA_WORD_ONES 16'hFFFF
`define SSFA_BYTE_ONES 16'h00FF
`define SSFA_WORD_MSB 16'h8000
`define SSFA_BYTE_MSB 16'h0080
`define SSFA_WORD_V_LO 16'h4000
`define SSFA_WORD_V_HI 16'hC000
`define SSFA_BYTE_V_LO 16'h0040
`define SSFA_BYTE_V_HI 16'h00C0
`define SSFA_SP_STEP 16'h0002
`define SSFA_SP_RESET 16'h0000
`define SSFA_PC_RESET 20'h00000

`endif

// ### inc/ssfa_pkg.sv
package ssfa_pkg;
  typedef enum logic [3:0] {
    SSFA_OP_ASL = 4'h0,
    SSFA_OP_CSL = 4'h1,
    SSFA_OP_ASR = 4'h2,
    SSFA_OP_CSR = 4'h3,
    SSFA_OP_SBC = 4'h4,
    SSFA_OP_CARRY_SET_OP = 4'h5,
    SSFA_OP_NEGATIVE_SET_OP = 4'h6,
    SSFA_OP_ZERO_SET_OP = 4'h7,
    SSFA_OP_SUB = 4'h8,
    SSFA_OP_INTERRUPT_RETURN = 4'h9
  } ssfa_op_t;

  typedef enum logic [4:0] {
    SSFA_ST_IDLE = 5'h01,
    SSFA_ST_SR_REQ = 5'h02,
    SSFA_ST_SR_GET = 5'h04,
    SSFA_ST_PC_REQ = 5'h08,
    SSFA_ST_PC_GET = 5'h10
  } ssfa_state_t;
endpackage

// ### design/ssfa_calc.sv
`timescale 1ns/10ps
`include "ssfa_map.svh"

module ssfa_calc
  import ssfa_pkg::*;
(
  input wire logic [3:0] op_i,
  input wire logic byte_i,
  input wire logic [15:0] dst_i,
  input wire logic [15:0] src_i,
  input wire logic [15:0] sr_i,
  output logic [15:0] res_o,
  output logic [15:0] sr_o
);
  logic [15:0] mask;
  logic [15:0] top;
  logic [15:0] dm;
  logic [15:0] addend;
  logic [16:0] sum;
  logic [15:0] res;
  logic c_in;
  logic d_msb;
  logic a_msb;
  logic r_msb;
  logic c_out;
  logic v_out;
  logic flags_upd;

  always_comb begin
    mask = byte_i ? `SSFA_BYTE_ONES : `SSFA_WORD_ONES;
    top = byte_i ? `SSFA_BYTE_MSB : `SSFA_WORD_MSB;
    dm = dst_i & mask;
    c_in = sr_i[`SSFA_SR_C];
    d_msb = |(dm & top);
    addend = mask;
    sum = 17'h00000;
    c_out = 1'b0;
    v_out = 1'b0;
    res = 16'h0000;
    flags_upd = 1'b1;
    sr_o = sr_i;
    unique case (ssfa_op_t'(op_i))
      SSFA_OP_ASL, SSFA_OP_CSL: begin
        // Low bit is zero or the old carry
        res = (dm << 1) | ((ssfa_op_t'(op_i) == SSFA_OP_CSL) ? {15'h0000, c_in} : 16'h0000);
        c_out = d_msb;
        v_out = byte_i ? (dm >= `SSFA_BYTE_V_LO && dm < `SSFA_BYTE_V_HI)
                       : (dm >= `SSFA_WORD_V_LO && dm < `SSFA_WORD_V_HI);
      end
      SSFA_OP_ASR: begin
        res = (dm >> 1) | (d_msb ? top : 16'h0000);
        c_out = dm[0];
      end
      SSFA_OP_CSR: begin
        res = (dm >> 1) | (c_in ? top : 16'h0000);
        c_out = dm[0];
      end
      SSFA_OP_SBC, SSFA_OP_SUB: begin
        // Borrow is carry inverted: C=1 means no borrow
        addend = (ssfa_op_t'(op_i) == SSFA_OP_SUB) ? (~src_i & mask) : mask;
        sum = {1'b0, dm} + {1'b0, addend}
            + {16'h0000, (ssfa_op_t'(op_i) == SSFA_OP_SUB) ? 1'b1 : c_in};
        res = sum[15:0];
        c_out = byte_i ? sum[8] : sum[16];
      end
      SSFA_OP_CARRY_SET_OP: begin
        flags_upd = 1'b0;
        sr_o = sr_i | `SSFA_SET_C_MASK;
      end
      SSFA_OP_NEGATIVE_SET_OP: begin
        flags_upd = 1'b0;
        sr_o = sr_i | `SSFA_SET_N_MASK;
      end
      SSFA_OP_ZERO_SET_OP: begin
        flags_upd = 1'b0;
        sr_o = sr_i | `SSFA_SET_Z_MASK;
      end
      default: begin
        flags_upd = 1'b0;
      end
    endcase
    res = res & mask;
    r_msb = |(res & top);
    a_msb = |(addend & top);
    if (ssfa_op_t'(op_i) == SSFA_OP_SBC || ssfa_op_t'(op_i) == SSFA_OP_SUB) begin
      // Operands of equal sign giving a result of the other sign
      v_out = (d_msb == a_msb) && (r_msb != d_msb);
    end
    if (flags_upd) begin
      // Only N, Z, C, V move; mode bits stay
      sr_o[`SSFA_SR_N] = r_msb;
      sr_o[`SSFA_SR_Z] = (res == 16'h0000);
      sr_o[`SSFA_SR_C] = c_out;
      sr_o[`SSFA_SR_V] = v_out;
    end
    res_o = res;
  end
endmodule

// ### design/ssfa_core.sv
`timescale 1ns/10ps
`include "ssfa_map.svh"

// How it works
// - Return pops status word, PC.19:16 from same word, then SP plus two.
// - Next stack word loads PC.15:0; SP plus two again; PC is 20 bits.
// - Return restores N, Z, C, V and the three mode bits from stack.
// - Arithmetic left shift: old MSB into C, zero into LSB.
// - Left shifts set V only for 4000h..BFFFh words, 40h..BFh bytes.
// - Carry left shift: old C into LSB, old MSB into C.
// - Arithmetic right shift keeps sign, copies it down, LSB to C, V clear.
// - Carry right shift: old C into MSB, LSB to C, V clear.
// - Shifts and borrow subtract: N from result MSB, Z when result zero.
// - Borrow subtract adds all ones of operand width plus C.
// - Borrow subtract: C one when no borrow, zero on borrow.
// - Borrow subtract sets V on signed overflow.
// - Carry set op sets C only.
// - Negative set op sets N; zero set op sets Z; nothing else.
// - Subtract adds inverted source plus one; source untouched; word or byte.
// - Shifts, borrow subtract and flag sets keep the three mode bits.
// - Subtract sets V when operand signs differ and result sign flips.
// - Subtract: C is carry out of MSB, N and Z from result.

module ssfa_core
  import ssfa_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] op_i,
  input wire logic byte_i,
  input wire logic [15:0] dst_i,
  input wire logic [15:0] src_i,
  input wire logic sr_wr_i,
  input wire logic [15:0] sr_wdata_i,
  input wire logic sp_wr_i,
  input wire logic [15:0] sp_wdata_i,
  input wire logic [15:0] mem_rdata_i,
  output logic [15:0] result_o,
  output logic [15:0] sr_o,
  output logic [19:0] pc_o,
  output logic [15:0] sp_o,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  output logic busy_o,
  output logic done_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  ssfa_state_t state_reg;
  ssfa_state_t state_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic [15:0] sr_reg;
  logic [15:0] sr_next;
  logic [19:0] pc_reg;
  logic [19:0] pc_next;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic rd_reg;
  logic rd_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic done_reg;
  logic done_next;
  logic busy_reg;
  logic busy_next;
  logic [15:0] calc_res;
  logic [15:0] calc_sr;
  logic idle;
  logic is_interrupt_return;

  assign idle = (state_reg == SSFA_ST_IDLE);
  assign is_interrupt_return = (ssfa_op_t'(op_i) == SSFA_OP_INTERRUPT_RETURN);

  ssfa_calc u_calc (
    .op_i(op_i),
    .byte_i(byte_i),
    .dst_i(dst_i),
    .src_i(src_i),
    .sr_i(sr_reg),
    .res_o(calc_res),
    .sr_o(calc_sr)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    result_next = result_reg;
    sr_next = sr_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    rd_next = 1'b0;
    addr_next = addr_reg;
    done_next = 1'b0;
    unique case (state_reg)
      SSFA_ST_IDLE: begin
        // Start beats a same-cycle status or stack pointer load
        if (start_i && is_interrupt_return) begin
          rd_next = 1'b1;
          addr_next = sp_reg;
          state_next = SSFA_ST_SR_REQ;
        end else if (start_i) begin
          result_next = calc_res;
          sr_next = calc_sr;
          done_next = 1'b1;
        end else begin
          if (sr_wr_i) begin
            sr_next = sr_wdata_i;
          end
          if (sp_wr_i) begin
            sp_next = sp_wdata_i;
          end
        end
      end
      SSFA_ST_SR_REQ: begin
        state_next = SSFA_ST_SR_GET;
      end
      SSFA_ST_SR_GET: begin
        // Only defined status bits are taken; spare bits read zero
        sr_next = mem_rdata_i & `SSFA_SR_KEEP;
        pc_next[19:16] = mem_rdata_i[`SSFA_SR_PCHI_MSB:`SSFA_SR_PCHI_LSB];
        sp_next = sp_reg + `SSFA_SP_STEP;
        rd_next = 1'b1;
        addr_next = sp_reg + `SSFA_SP_STEP;
        state_next = SSFA_ST_PC_REQ;
      end
      SSFA_ST_PC_REQ: begin
        state_next = SSFA_ST_PC_GET;
      end
      SSFA_ST_PC_GET: begin
        pc_next[15:0] = mem_rdata_i;
        sp_next = sp_reg + `SSFA_SP_STEP;
        done_next = 1'b1;
        state_next = SSFA_ST_IDLE;
      end
    endcase
    // Taken from the next state so busy_o rises with the first stack read
    busy_next = (state_next != SSFA_ST_IDLE);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= SSFA_ST_IDLE;
      result_reg <= 16'h0000;
      sr_reg <= `SSFA_SR_RESET;
      pc_reg <= `SSFA_PC_RESET;
      sp_reg <= `SSFA_SP_RESET;
      rd_reg <= 1'b0;
      addr_reg <= 16'h0000;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      result_reg <= result_next;
      sr_reg <= sr_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
    end
  end

  assign result_o = result_reg;
  assign sr_o = sr_reg;
  assign pc_o = pc_reg;
  assign sp_o = sp_reg;
  assign mem_rd_o = rd_reg;
  assign mem_addr_o = addr_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence interrupt_return_go;
    idle && start_i && is_interrupt_return;
  endsequence

  sequence word_go(ssfa_op_t o);
    idle && start_i && !byte_i && ssfa_op_t'(op_i) == o;
  endsequence

  AST_INTERRUPT_RETURN_FIRST_READ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    interrupt_return_go |=> mem_rd_o && mem_addr_o == $past(sp_reg))
    else $error("first stack read wrong");

  AST_INTERRUPT_RETURN_SP_FOUR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    interrupt_return_go |-> ##5 done_o && sp_o == $past(sp_reg, 5) + `SSFA_SP_STEP + `SSFA_SP_STEP)
    else $error("return did not advance stack pointer by four");

  AST_INTERRUPT_RETURN_SR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_reg == SSFA_ST_SR_GET |=> sr_o == ($past(mem_rdata_i) & `SSFA_SR_KEEP)
      && pc_o[19:16] == $past(mem_rdata_i[`SSFA_SR_PCHI_MSB:`SSFA_SR_PCHI_LSB]))
    else $error("status word not restored");

  AST_INTERRUPT_RETURN_PC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_reg == SSFA_ST_PC_GET |=> pc_o[15:0] == $past(mem_rdata_i) && idle)
    else $error("low program counter not restored");

  AST_ASL_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_ASL) |=> result_o == {$past(dst_i[14:0]), 1'b0}
      && sr_o[`SSFA_SR_C] == $past(dst_i[15]))
    else $error("arithmetic left shift wrong");

  AST_CSR_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_CSR) |=> result_o[15] == $past(sr_reg[`SSFA_SR_C])
      && sr_o[`SSFA_SR_C] == $past(dst_i[0]) && !sr_o[`SSFA_SR_V])
    else $error("carry right shift wrong");

  AST_SUB_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_SUB) |=> result_o == $past(dst_i) - $past(src_i)
      && sr_o[`SSFA_SR_Z] == ($past(dst_i) == $past(src_i)))
    else $error("subtract wrong");

  AST_CARRY_SET_OP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && ssfa_op_t'(op_i) == SSFA_OP_CARRY_SET_OP
    |=> sr_o == ($past(sr_reg) | `SSFA_SET_C_MASK))
    else $error("carry set op wrong");

  AST_MODE_KEEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && !is_interrupt_return |=> (sr_o & `SSFA_SR_MODE) == ($past(sr_reg) & `SSFA_SR_MODE))
    else $error("mode bits disturbed");

  sequence sr_fetch;
    state_reg == SSFA_ST_SR_GET;
  endsequence

  sequence pc_fetch;
    state_reg == SSFA_ST_PC_GET;
  endsequence

  AST_INTERRUPT_RETURN_SECOND_READ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sr_fetch |=> mem_rd_o && mem_addr_o == $past(sp_reg) + `SSFA_SP_STEP)
    else $error("second stack read wrong");

  AST_INTERRUPT_RETURN_SP_STEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sr_fetch |=> sp_o == $past(sp_reg) + `SSFA_SP_STEP)
    else $error("stack pointer not advanced after status pop");

  AST_INTERRUPT_RETURN_BUSY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    interrupt_return_go |=> busy_o [*4] ##1 !busy_o)
    else $error("busy window of return wrong");

  AST_INTERRUPT_RETURN_DONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pc_fetch |=> done_o && !busy_o)
    else $error("return did not complete");

  AST_INTERRUPT_RETURN_LOAD_REFUSED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_reg == SSFA_ST_SR_REQ |=> sr_o == $past(sr_reg))
    else $error("status changed while waiting for stack word");

  AST_PC_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle |=> pc_o == $past(pc_reg))
    else $error("program counter moved outside return");

  AST_CSL_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_CSL) |=> result_o == (($past(dst_i) << 1) | {15'h0000, $past(sr_reg[`SSFA_SR_C])})
      && sr_o[`SSFA_SR_C] == |($past(dst_i) & `SSFA_WORD_MSB))
    else $error("carry left shift wrong");

  AST_ASR_WORD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_ASR) |=> result_o == (($past(dst_i) >> 1) | ($past(dst_i) & `SSFA_WORD_MSB))
      && sr_o[`SSFA_SR_C] == $past(dst_i[0]) && !sr_o[`SSFA_SR_V])
    else $error("arithmetic right shift wrong");

  AST_SHIFT_V: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_CSL) |=> sr_o[`SSFA_SR_V]
      == ($past(dst_i) >= `SSFA_WORD_V_LO && $past(dst_i) < `SSFA_WORD_V_HI))
    else $error("word left shift overflow wrong");

  AST_SHIFT_V_BYTE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && byte_i && ssfa_op_t'(op_i) == SSFA_OP_ASL |=> sr_o[`SSFA_SR_V]
      == (($past(dst_i) & `SSFA_BYTE_ONES) >= `SSFA_BYTE_V_LO
      && ($past(dst_i) & `SSFA_BYTE_ONES) < `SSFA_BYTE_V_HI))
    else $error("byte left shift overflow wrong");

  AST_SBC_RESULT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_SBC) |=> result_o == $past(dst_i) + `SSFA_WORD_ONES
      + {15'h0000, $past(sr_reg[`SSFA_SR_C])})
    else $error("borrow subtract result wrong");

  AST_SBC_CARRY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_SBC) |=> sr_o[`SSFA_SR_C]
      == ($past(dst_i) != 16'h0000 || $past(sr_reg[`SSFA_SR_C])))
    else $error("borrow subtract carry wrong");

  AST_SBC_V: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_SBC) |=> sr_o[`SSFA_SR_V]
      == ($past(dst_i) == `SSFA_WORD_MSB && !$past(sr_reg[`SSFA_SR_C])))
    else $error("borrow subtract overflow wrong");

  AST_SUB_V: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_SUB) |=> sr_o[`SSFA_SR_V] == (($past(dst_i[15]) != $past(src_i[15]))
      && (result_o[15] != $past(dst_i[15]))))
    else $error("subtract overflow wrong");

  AST_SUB_CN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    word_go(SSFA_OP_SUB) |=> sr_o[`SSFA_SR_C] == ($past(dst_i) >= $past(src_i))
      && sr_o[`SSFA_SR_N] == result_o[15])
    else $error("subtract carry or negative wrong");

  AST_NEGATIVE_SET_OP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && ssfa_op_t'(op_i) == SSFA_OP_NEGATIVE_SET_OP
    |=> sr_o == ($past(sr_reg) | `SSFA_SET_N_MASK))
    else $error("negative set op wrong");

  AST_ZERO_SET_OP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && ssfa_op_t'(op_i) == SSFA_OP_ZERO_SET_OP
    |=> sr_o == ($past(sr_reg) | `SSFA_SET_Z_MASK))
    else $error("zero set op wrong");

  AST_FLAG_NZ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && ssfa_op_t'(op_i) inside {SSFA_OP_ASL, SSFA_OP_CSL, SSFA_OP_ASR,
      SSFA_OP_CSR, SSFA_OP_SBC}
    |=> sr_o[`SSFA_SR_N] == |(result_o & ($past(byte_i) ? `SSFA_BYTE_MSB : `SSFA_WORD_MSB))
      && sr_o[`SSFA_SR_Z] == (result_o == 16'h0000))
    else $error("negative or zero flag wrong");

  AST_BYTE_UPPER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    idle && start_i && byte_i && !is_interrupt_return |=> (result_o & ~`SSFA_BYTE_ONES) == 16'h0000)
    else $error("byte form touched upper byte");
endmodule

// ### tb/ssfa_core_tb.sv
`timescale 1ns/10ps

`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module ssfa_core_tb
  import ssfa_pkg::*;
;
  // ----------------------------------------
  // Stimulus and expectations
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] res;
    logic [15:0] sr;
    logic [19:0] pc;
    logic [15:0] sp;
  } ssfa_exp_t;

  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic byte_i = 1'b0;
  logic sr_wr_i = 1'b0;
  logic sp_wr_i = 1'b0;
  logic [3:0] op_i = 4'h0;
  logic [15:0] dst_i = 16'h0000;
  logic [15:0] src_i = 16'h0000;
  logic [15:0] sr_wdata_i = 16'h0000;
  logic [15:0] sp_wdata_i = 16'h0000;
  logic [15:0] mem_rdata_i = 16'h0000;
  logic [15:0] result_o;
  logic [15:0] sr_o;
  logic [19:0] pc_o;
  logic [15:0] sp_o;
  logic mem_rd_o;
  logic [15:0] mem_addr_o;
  logic busy_o;
  logic done_o;
  ssfa_exp_t exp_q[$];
  ssfa_exp_t mon_e;
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 55422;
  logic [15:0] cur_res = 16'h0000;
  logic [15:0] cur_sr = 16'h0000;
  logic [15:0] cur_sp = 16'h0000;
  logic [19:0] cur_pc = 20'h00000;

  always #12.5 clk_sys_i = ~clk_sys_i;

  ssfa_core ssfa_core_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i), .byte_i(byte_i),
    .dst_i(dst_i), .src_i(src_i), .sr_wr_i(sr_wr_i), .sr_wdata_i(sr_wdata_i),
    .sp_wr_i(sp_wr_i), .sp_wdata_i(sp_wdata_i), .mem_rdata_i(mem_rdata_i),
    .result_o(result_o), .sr_o(sr_o), .pc_o(pc_o), .sp_o(sp_o), .mem_rd_o(mem_rd_o),
    .mem_addr_o(mem_addr_o), .busy_o(busy_o), .done_o(done_o)
  );

  // Independent reference of the operations
  function automatic logic [31:0] ssfa_model(input logic [3:0] op, input logic byt,
      input logic [15:0] d0, input logic [15:0] s0, input logic [15:0] sr,
      input logic [15:0] rp);
    logic [15:0] msk, top, d, s, r;
    logic [16:0] sum;
    logic c, v;
    msk = byt ? 16'h00FF : 16'hFFFF;
    top = byt ? 16'h0080 : 16'h8000;
    d = d0 & msk;
    s = s0 & msk;
    c = sr[0];
    v = 1'b0;
    r = rp;
    sum = 17'h00000;
    case (op)
      4'h0, 4'h1: begin
        r = ((d << 1) | (op[0] ? {15'h0000, sr[0]} : 16'h0000)) & msk;
        c = |(d & top);
        v = byt ? (d >= 16'h0040 && d < 16'h00C0) : (d >= 16'h4000 && d < 16'hC000);
      end
      4'h2, 4'h3: begin
        r = (d >> 1) | ((op[0] ? sr[0] : |(d & top)) ? top : 16'h0000);
        c = d[0];
      end
      4'h4, 4'h8: begin
        sum = {1'b0, d} + (op[3] ? {1'b0, ~s & msk} + 17'h00001 : {1'b0, msk} + {16'h0000, sr[0]});
        r = sum[15:0] & msk;
        c = byt ? sum[8] : sum[16];
        v = (|(d & top) == (op[3] ? ~|(s & top) : 1'b1)) && (|(r & top) != |(d & top));
      end
      // Flag ops drive a zero result
      4'h5: return {16'h0000, sr | 16'h0001};
      4'h6: return {16'h0000, sr | 16'h0004};
      4'h7: return {16'h0000, sr | 16'h0002};
      default: ;
    endcase
    return {r, (sr & 16'hFEF8) | {7'h00, v, 5'h00, |(r & top), r == 16'h0000, c}};
  endfunction

  task automatic tally_and_finish();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic alu(input logic [3:0] op, input logic byt, input logic [15:0] d,
      input logic [15:0] s);
    logic [31:0] m;
    @(posedge clk_sys_i);
    m = ssfa_model(op, byt, d, s, cur_sr, cur_res);
    cur_res = m[31:16];
    cur_sr = m[15:0];
    exp_q.push_back('{cur_res, cur_sr, cur_pc, cur_sp});
    start_i <= 1'b1;
    op_i <= op;
    byte_i <= byt;
    dst_i <= d;
    src_i <= s;
  endtask

  task automatic idle();
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    sr_wr_i <= 1'b0;
    sp_wr_i <= 1'b0;
  endtask

  task automatic load(input logic to_sp, input logic [15:0] v);
    @(posedge clk_sys_i);
    if (to_sp) begin
      sp_wr_i <= 1'b1;
      sp_wdata_i <= v;
      cur_sp = v;
    end else begin
      sr_wr_i <= 1'b1;
      sr_wdata_i <= v;
      cur_sr = v;
    end
    idle();
  endtask

  // Return sequence; a start and a status load are offered while busy and must be ignored
  task automatic interrupt_return(input logic [15:0] w_sr, input logic [15:0] w_pc);
    logic [15:0] w[2];
    logic [15:0] base;
    logic hit;
    w[0] = w_sr;
    w[1] = w_pc;
    base = cur_sp;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    op_i <= 4'h9;
    cur_sr = w_sr & 16'h013F;
    cur_pc = {w_sr[15:12], w_pc};
    cur_sp = base + 16'h0004;
    exp_q.push_back('{cur_res, cur_sr, cur_pc, cur_sp});
    @(posedge clk_sys_i);
    op_i <= 4'h5;
    sr_wr_i <= 1'b1;
    sr_wdata_i <= 16'h0107;
    for (int j = 0; j < 2; j++) begin
      hit = 1'b0;
      for (int k = 0; k < 8 && !hit; k++) begin
        @(posedge clk_sys_i);
        hit = (mem_rd_o === 1'b1);
        mem_rdata_i <= hit ? w[j] : ~w[j];
        start_i <= 1'b0;
        sr_wr_i <= 1'b0;
      end
      if (!hit) begin
        n_mismatch++;
        tally_and_finish();
      end
      `CHK("mem_addr_o", base + 16'h0002 * j[15:0], mem_addr_o)
      `CHK("busy_o", 1'b1, busy_o)
    end
    @(posedge clk_sys_i);
    mem_rdata_i <= ~w[1];
  endtask

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_i && done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] done_o expected 0 seen 1");
      end else begin
        mon_e = exp_q.pop_front();
        `CHK("result_o", mon_e.res, result_o)
        `CHK("sr_o", mon_e.sr, sr_o)
        `CHK("pc_o", mon_e.pc, pc_o)
        `CHK("sp_o", mon_e.sp, sp_o)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] dtab[10];
    dtab = '{16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000, 16'h003F, 16'h0040, 16'h00BF,
      16'h00C0, 16'h0000, 16'h0001};
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    `CHK("sr_o", 16'h0000, sr_o)
    `CHK("pc_o", 20'h00000, pc_o)
    load(1'b1, 16'h0200);
    // Boundary operands, both widths, every code except return, back to back
    for (int op = 0; op < 9; op++) begin
      load(1'b0, 16'($random(seed)));
      for (int b = 0; b < 2; b++) begin
        foreach (dtab[i]) begin
          alu(op[3:0], b[0], dtab[i], 16'($random(seed)));
        end
      end
      idle();
    end
    interrupt_return(16'hA13F, 16'h1234);
    interrupt_return(16'h5FC6, 16'hFFFE);
    for (int n = 0; n < 400; n++) begin
      alu(4'($unsigned($random(seed)) % 9), 1'($random(seed)), 16'($random(seed)),
        16'($random(seed)));
      if (n % 50 == 49) begin
        idle();
        load(1'b1, 16'($random(seed)) & 16'hFFFE);
        interrupt_return(16'($random(seed)), 16'($random(seed)));
      end
    end
    idle();
    repeat (4) @(posedge clk_sys_i);
    `CHK("pending results", 0, exp_q.size())
    tally_and_finish();
  end
endmodule
